/* File: sine_pwm_commutation_control.sv */
// Commutation, sine PWM and protection logic for a three-phase BLDC driver
// How it works
// - Start with 120 degree square drive; above 2.5 Hz use 180 degree sine PWM.
// - Switchover threshold is reference frequency over 2^13 times 41 times 6.
// - Sine PWM per phase compares modulated sample against the triangle carrier.
// - Speed command at or below 0.5 V turns all drive outputs off.
// - Waveform amplitude scales with speed command; full code gives 100 percent.
// - Triangle carrier runs at reference frequency divided by 252.
// - Drive leads Hall phase by 0 to 29 degrees in 32 steps.
// - Rotation pulse output gives three pulses per electrical cycle.
// - Direction is judged from Hall order every 360 degrees, then mode chosen.
// - Rotation matching direction select gives 180 degree, opposite gives 120.
// - Below 2.5 Hz Hall rate, 120 degree drive is always forced.
// - Overcurrent turns outputs off; state clears at each carrier cycle start.
// - External reset high holds outputs off; low releases them.
// - All Hall signals equal turns outputs off; retry each carrier cycle.
// - Failure to reach 180 degree drive counts as lock; outputs turned off. Here only a Hall rate below 2.5 Hz is timed, in either direction.
// - One period, base interval times 1024, times lock watch and off time.
// - Restart select high: alternate on and off periods until sine mode. Here on periods end once the Hall rate reaches 2.5 Hz, in either direction.
// - Restart select low: latch off until supply low or speed stopped.
// - Outputs stay off while the supply monitor reports supply out of range.
// - Lead angle applies only at 2.5 Hz or above, else zero.
// - Each 60 degree segment has 32 samples of 1/32 previous Hall interval.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module sine_pwm_commutation_control #(
  parameter int SLOW_EDGE_CYCLES = motor_pkg::SLOW_EDGE_TICKS,
  parameter int LOCK_BASE_CYCLES = motor_pkg::LOCK_BASE_TICKS
) (
  input wire logic pclk, // System clock, 50 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [2:0] hall_in, // Hall comparators {u,v,w}
  input wire logic [7:0] speed_command_level, // Speed command code
  input wire logic [4:0] lead_angle_setting, // Lead angle step code
  input wire logic direction_select, // Low clockwise, high counterclockwise
  input wire logic lock_restart_select, // High selects automatic restart
  input wire logic current_sense_input, // Current comparator above limit
  input wire logic ext_reset_in, // External shutdown, high turns off
  input wire logic motor_supply_ok, // Supply monitor in range
  output motor_pkg::phase_drive_type phase_drive, // Gate drive per phase
  output logic rotation_pulse_out // Three pulses per electrical cycle
);
  import motor_pkg::*;

  function automatic logic [2:0] sector_of(input logic [2:0] h);
    case (h)
      3'b100: sector_of = 3'h0;
      3'b110: sector_of = 3'h1;
      3'b010: sector_of = 3'h2;
      3'b011: sector_of = 3'h3;
      3'b001: sector_of = 3'h4;
      3'b101: sector_of = 3'h5;
      default: sector_of = SECTOR_BAD;
    endcase
  endfunction : sector_of

  function automatic logic [8:0] ang_add(input logic [8:0] a,
                                         input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, ANG_FULL}) begin
      s = s - {1'b0, ANG_FULL};
    end
    ang_add = s[8:0];
  endfunction : ang_add

  // Parabolic half waves stand in for a sine table to save area
  function automatic logic [6:0] wave_duty(input logic [8:0] ang,
                                           input logic [7:0] amp);
    logic [8:0] x;
    logic [13:0] prod;
    logic [21:0] scaled;
    logic [5:0] mag;
    x = (ang >= ANG_HALF) ? ang - ANG_HALF : ang;
    prod = 14'(x) * 14'(ANG_HALF - x);
    scaled = (22'(prod) * 22'(amp)) / 22'(WAVE_DIV);
    mag = scaled[5:0];
    wave_duty = (ang >= ANG_HALF) ? DUTY_MID - 7'(mag) : DUTY_MID + 7'(mag);
  endfunction : wave_duty

  // Reference tick and carrier
  logic [3:0] ref_cnt_ff, nxt_ref_cnt;
  logic [6:0] tri_ff, nxt_tri;
  logic tri_down_ff, nxt_tri_down;
  logic ref_tick, carrier_start;

  always_comb begin
    nxt_ref_cnt = ref_cnt_ff;
    nxt_tri = tri_ff;
    nxt_tri_down = tri_down_ff;
    ref_tick = (ref_cnt_ff == REF_DIV - 4'h1);
    if (ref_tick) begin
      nxt_ref_cnt = 4'h0;
      if (!tri_down_ff) begin
        if (tri_ff == TRI_TOP) nxt_tri_down = 1'b1;
        else nxt_tri = tri_ff + 7'h01;
      end else begin
        if (tri_ff == 7'h00) nxt_tri_down = 1'b0;
        else nxt_tri = tri_ff - 7'h01;
      end
    end else begin
      nxt_ref_cnt = ref_cnt_ff + 4'h1;
    end
    carrier_start = ref_tick && tri_down_ff && (tri_ff == 7'h00);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_ff <= 4'h0;
      tri_ff <= 7'h00;
      tri_down_ff <= 1'b0;
    end else if (clk_en) begin
      ref_cnt_ff <= nxt_ref_cnt;
      tri_ff <= nxt_tri;
      tri_down_ff <= nxt_tri_down;
    end
  end

  // Hall timing, direction and waveform position
  logic [2:0] hall_prev_ff, nxt_hall_prev;
  logic [20:0] edge_cnt_ff, nxt_edge_cnt;
  logic [20:0] period_ff, nxt_period;
  logic [15:0] samp_cnt_ff, nxt_samp_cnt;
  logic [7:0] pos_ff, nxt_pos;
  logic [2:0] edges_ff, nxt_edges;
  logic rev_seen_ff, nxt_rev_seen;
  logic dir_match_ff, nxt_dir_match;
  logic pulse_ff, nxt_pulse;
  logic [2:0] sector, prev_sector, sector_up;
  logic hall_edge, slow, step_ccw;

  always_comb begin
    sector = sector_of(hall_in);
    prev_sector = sector_of(hall_prev_ff);
    sector_up = (prev_sector == SECTOR_LAST) ? 3'h0 : prev_sector + 3'h1;
    // Steps out of reset or a fault code are not real edges
    hall_edge = (hall_in != hall_prev_ff) && (sector != SECTOR_BAD) &&
                (prev_sector != SECTOR_BAD);
    step_ccw = (sector != sector_up);
    slow = (period_ff > 21'(SLOW_EDGE_CYCLES)) ||
           (edge_cnt_ff > 21'(SLOW_EDGE_CYCLES));
    nxt_hall_prev = hall_in;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_period = period_ff;
    nxt_samp_cnt = samp_cnt_ff;
    nxt_pos = pos_ff;
    nxt_edges = edges_ff;
    nxt_rev_seen = rev_seen_ff;
    nxt_dir_match = dir_match_ff;
    nxt_pulse = ^hall_in;
    if (hall_edge) begin
      nxt_period = edge_cnt_ff;
      nxt_edge_cnt = 21'h0;
      nxt_samp_cnt = 16'h0;
      // Realign waveform at every zero cross
      nxt_pos = direction_select ? 8'((SECTOR_LAST - sector) * 32)
                                 : 8'(sector * 32);
      nxt_rev_seen = rev_seen_ff | (step_ccw != direction_select);
      if (edges_ff == SECTOR_LAST) begin
        nxt_edges = 3'h0;
        nxt_dir_match = !(rev_seen_ff | (step_ccw != direction_select));
        nxt_rev_seen = 1'b0;
      end else begin
        nxt_edges = edges_ff + 3'h1;
      end
    end else if (ref_tick) begin
      if (edge_cnt_ff != 21'h1F_FFFF) nxt_edge_cnt = edge_cnt_ff + 21'h1;
      // Keep stepping with the old period if the next edge is late
      if (samp_cnt_ff >= period_ff[20:5]) begin
        nxt_samp_cnt = 16'h0;
        nxt_pos = (pos_ff == POS_LAST) ? 8'h00 : pos_ff + 8'h01;
      end else begin
        nxt_samp_cnt = samp_cnt_ff + 16'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_prev_ff <= 3'h0;
      edge_cnt_ff <= 21'h1F_FFFF;
      period_ff <= 21'h1F_FFFF;
      samp_cnt_ff <= 16'h0;
      pos_ff <= 8'h00;
      edges_ff <= 3'h0;
      rev_seen_ff <= 1'b0;
      dir_match_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else if (clk_en) begin
      hall_prev_ff <= nxt_hall_prev;
      edge_cnt_ff <= nxt_edge_cnt;
      period_ff <= nxt_period;
      samp_cnt_ff <= nxt_samp_cnt;
      pos_ff <= nxt_pos;
      edges_ff <= nxt_edges;
      rev_seen_ff <= nxt_rev_seen;
      dir_match_ff <= nxt_dir_match;
      pulse_ff <= nxt_pulse;
    end
  end

  // Protection flags and lock supervision
  logic oc_ff, nxt_oc;
  logic fault_ff, nxt_fault;
  lock_state_type lock_ff, nxt_lock;
  logic [15:0] base_cnt_ff, nxt_base_cnt;
  logic [9:0] lock_cnt_ff, nxt_lock_cnt;
  logic speed_on, lock_expire, base_tick, sine_mode;
  logic ctrl_run, lead_from_reg;
  logic [4:0] lead_reg;

  always_comb begin
    speed_on = (speed_command_level > SPEED_STOP_CODE);
    sine_mode = !slow && dir_match_ff;
    base_tick = ref_tick && (base_cnt_ff == 16'(LOCK_BASE_CYCLES - 1));
    lock_expire = base_tick && (lock_cnt_ff == LOCK_LAST);
    // Set wins over the carrier-start clear
    nxt_oc = current_sense_input | (oc_ff & !carrier_start);
    nxt_fault = (sector == SECTOR_BAD) | (fault_ff & !carrier_start);
    nxt_lock = lock_ff;
    nxt_base_cnt = base_cnt_ff;
    nxt_lock_cnt = lock_cnt_ff;
    if (ref_tick) begin
      nxt_base_cnt = base_tick ? 16'h0 : base_cnt_ff + 16'h1;
      if (base_tick) nxt_lock_cnt = lock_cnt_ff + 10'h001;
    end
    case (lock_ff)
      LOCK_WATCH: begin
        // Stopped or switched over motors never time out
        if (!slow || !speed_on || !motor_supply_ok) begin
          nxt_base_cnt = 16'h0;
          nxt_lock_cnt = 10'h000;
        end else if (lock_expire) begin
          nxt_lock = lock_restart_select ? LOCK_OFF : LOCK_LATCH;
        end
      end
      LOCK_OFF: begin
        if (lock_expire) nxt_lock = LOCK_ON;
      end
      LOCK_ON: begin
        if (!slow) begin
          nxt_lock = LOCK_WATCH;
          nxt_base_cnt = 16'h0;
          nxt_lock_cnt = 10'h000;
        end else if (lock_expire) begin
          nxt_lock = LOCK_OFF;
        end
      end
      LOCK_LATCH: begin
        if (!motor_supply_ok || !speed_on) begin
          nxt_lock = LOCK_WATCH;
          nxt_base_cnt = 16'h0;
          nxt_lock_cnt = 10'h000;
        end
      end
      default: nxt_lock = LOCK_WATCH;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_ff <= 1'b0;
      fault_ff <= 1'b0;
      lock_ff <= LOCK_WATCH;
      base_cnt_ff <= 16'h0;
      lock_cnt_ff <= 10'h000;
    end else if (clk_en) begin
      oc_ff <= nxt_oc;
      fault_ff <= nxt_fault;
      lock_ff <= nxt_lock;
      base_cnt_ff <= nxt_base_cnt;
      lock_cnt_ff <= nxt_lock_cnt;
    end
  end

  // Drive generation
  phase_drive_type drive_ff, nxt_drive;
  logic rot_ff;
  logic drive_ok;
  logic [4:0] lead;
  logic [8:0] base_ang, ang_u, ang_v, ang_w;
  logic [2:0] cmp, hi_sel, lo_sel;
  logic chop;

  always_comb begin
    lead = lead_from_reg ? lead_reg : lead_angle_setting;
    if (!sine_mode) lead = 5'h00;
    // One lead step is half a waveform sample, about 0.94 degree
    base_ang = ang_add({pos_ff, 1'b0}, {4'h0, lead});
    ang_u = base_ang;
    ang_v = ang_add(base_ang, direction_select ? ANG_120 : ANG_240);
    ang_w = ang_add(base_ang, direction_select ? ANG_240 : ANG_120);
    cmp[2] = wave_duty(ang_u, speed_command_level) > tri_ff;
    cmp[1] = wave_duty(ang_v, speed_command_level) > tri_ff;
    cmp[0] = wave_duty(ang_w, speed_command_level) > tri_ff;
    chop = speed_command_level[7:1] > tri_ff;
    case (sector)
      3'h0: begin hi_sel = 3'b100; lo_sel = 3'b010; end
      3'h1: begin hi_sel = 3'b100; lo_sel = 3'b001; end
      3'h2: begin hi_sel = 3'b010; lo_sel = 3'b001; end
      3'h3: begin hi_sel = 3'b010; lo_sel = 3'b100; end
      3'h4: begin hi_sel = 3'b001; lo_sel = 3'b100; end
      3'h5: begin hi_sel = 3'b001; lo_sel = 3'b010; end
      default: begin hi_sel = 3'b000; lo_sel = 3'b000; end
    endcase
    drive_ok = ctrl_run && speed_on
               && !ext_reset_in
               && !oc_ff
               && !fault_ff
               && motor_supply_ok
               && (lock_ff == LOCK_WATCH || lock_ff == LOCK_ON);
    nxt_drive = '0;
    if (drive_ok) begin
      if (sine_mode) begin
        nxt_drive.high = cmp;
        nxt_drive.low = ~cmp;
      end else if (direction_select) begin
        nxt_drive.high = lo_sel & {3{chop}};
        nxt_drive.low = hi_sel;
      end else begin
        nxt_drive.high = hi_sel & {3{chop}};
        nxt_drive.low = lo_sel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_ff <= '0;
      rot_ff <= 1'b0;
    end else if (clk_en) begin
      drive_ff <= nxt_drive;
      rot_ff <= pulse_ff;
    end
  end

  assign phase_drive = drive_ff;
  assign rotation_pulse_out = rot_ff;

  // APB slave, zero wait states; read data is captured in the setup phase
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err;
  status_type status;
  logic setup, wr_access, mapped;

  always_comb begin
    status.sector = sector;
    status.drive_active = drive_ok;
    status.lock_off = (lock_ff == LOCK_OFF);
    status.lock_latched = (lock_ff == LOCK_LATCH);
    status.pos_fault = fault_ff;
    status.over_current = oc_ff;
    status.dir_match = dir_match_ff;
    status.slow = slow;
    status.sine_mode = sine_mode;
    setup = psel && !penable;
    mapped = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR) ||
             (paddr == PERIOD_ADDR);
    wr_access = psel && penable && pwrite && !err_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_err = !mapped;
      case (paddr)
        CTRL_ADDR: nxt_rdata = ctrl_ff;
        STATUS_ADDR: nxt_rdata = {21'h0, status};
        PERIOD_ADDR: nxt_rdata = {11'h0, period_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    if (wr_access && paddr == CTRL_ADDR) begin
      nxt_ctrl = pwdata & CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else if (clk_en) begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  assign ctrl_run = ctrl_ff[CTRL_RUN_BIT];
  assign lead_from_reg = ctrl_ff[CTRL_LEAD_SRC_BIT];
  assign lead_reg = ctrl_ff[CTRL_LEAD_LSB +: 5];
  assign prdata = rdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_ff;
endmodule : sine_pwm_commutation_control

/* File: motor_pkg.sv */
// Constants and lock, drive and status types for the sine PWM commutation block
package motor_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int REF_HZ = 5_000_000;
  localparam logic [3:0] REF_DIV = 4'(CLK_HZ / REF_HZ);
  // Switchover: one 60 degree interval at 2.5 Hz, in reference ticks
  localparam int SLOW_POW2 = 8192;
  localparam int SLOW_MUL = 41;
  localparam int SLOW_SECTORS = 6;
  localparam int SLOW_EDGE_TICKS = SLOW_POW2 * SLOW_MUL;
  // Carrier: triangle of CARRIER_DIV reference ticks per cycle
  localparam int CARRIER_DIV = 252;
  localparam logic [6:0] TRI_TOP = 7'(CARRIER_DIV / 2 - 1);
  // Lock period: base interval times LOCK_TICKS
  localparam int LOCK_TIME_MS = 500;
  localparam int LOCK_TICKS = 1024;
  localparam logic [9:0] LOCK_LAST = 10'(LOCK_TICKS - 1);
  localparam int LOCK_BASE_TICKS = REF_HZ / 1000 * LOCK_TIME_MS / LOCK_TICKS;
  // Waveform geometry
  localparam logic [7:0] POS_LAST = 8'h00_BF;
  localparam logic [8:0] ANG_FULL = 9'h0_180;
  localparam logic [8:0] ANG_HALF = 9'h0_0C0;
  localparam logic [8:0] ANG_120 = 9'h0_080;
  localparam logic [8:0] ANG_240 = 9'h1_00;
  localparam logic [6:0] DUTY_MID = 7'h40;
  localparam int WAVE_DIV = 36864;
  localparam logic [2:0] SECTOR_BAD = 3'h7;
  localparam logic [2:0] SECTOR_LAST = 3'h5;
  // Speed command code at or below which drive stops (0.5 V of 4.4 V)
  localparam logic [7:0] SPEED_STOP_CODE = 8'h1D;
  // APB map
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] PERIOD_ADDR = 8'h08;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_LEAD_SRC_BIT = 1;
  localparam int CTRL_LEAD_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK = 32'h0000_1F03;

  typedef enum logic [3:0] {
    LOCK_WATCH = 4'b0001,
    LOCK_OFF = 4'b0010,
    LOCK_ON = 4'b0100,
    LOCK_LATCH = 4'b1000
  } lock_state_type;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } phase_drive_type;

  typedef struct packed {
    logic [2:0] sector;
    logic drive_active;
    logic lock_off;
    logic lock_latched;
    logic pos_fault;
    logic over_current;
    logic dir_match;
    logic slow;
    logic sine_mode;
  } status_type;
endpackage : motor_pkg

/* File: commutation_properties.sv */
// Port checks for the commutation block, with its bind
`timescale 1ns/100ps
module commutation_properties (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [2:0] hall_in, // Hall levels
  input wire logic [7:0] speed_command_level, // Speed code
  input wire logic current_sense_input, // Overcurrent
  input wire logic ext_reset_in, // External off
  input wire logic motor_supply_ok, // Supply in range
  input wire motor_pkg::phase_drive_type phase_drive, // Gate drive
  input wire logic rotation_pulse_out // Pulse output
);
  import motor_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_speed_stop;
    speed_command_level <= SPEED_STOP_CODE |=> phase_drive == '0;
  endproperty
  a_speed_stop: assert property (p_speed_stop)
    else $error("drive on while speed stopped");
  property p_ext_off;
    ext_reset_in |=> phase_drive == '0;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("drive on during external reset");
  property p_supply_off;
    !motor_supply_ok |=> phase_drive == '0;
  endproperty
  a_supply_off: assert property (p_supply_off)
    else $error("drive on with supply out of range");
  // Flag registers first, so the drive follows one edge later
  property p_oc_off;
    current_sense_input |-> ##2 phase_drive == '0;
  endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("drive on after overcurrent");
  property p_hall_high;
    hall_in == 3'h7 |-> ##2 phase_drive == '0;
  endproperty
  a_hall_high: assert property (p_hall_high)
    else $error("drive on with all Hall high");
  property p_hall_low;
    (hall_in == 3'h0) [*2] |=> phase_drive == '0;
  endproperty
  a_hall_low: assert property (p_hall_low)
    else $error("drive on with all Hall low");
  property p_pulse;
    $changed(^hall_in) |-> ##2 rotation_pulse_out == $past(^hall_in, 2);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("rotation pulse does not follow Hall edges");
  property p_no_short;
    (phase_drive.high & phase_drive.low) == 3'h0;
  endproperty
  a_no_short: assert property (p_no_short)
    else $error("high and low side on together");
  c_oc: cover property (current_sense_input ##2 phase_drive == '0);
  c_fault: cover property (hall_in == 3'h7);
  c_pulse: cover property ($rose(rotation_pulse_out));
endmodule : commutation_properties

bind sine_pwm_commutation_control commutation_properties chk_u (
  .pclk(pclk), .presetn(presetn), .hall_in(hall_in),
  .speed_command_level(speed_command_level),
  .current_sense_input(current_sense_input), .ext_reset_in(ext_reset_in),
  .motor_supply_ok(motor_supply_ok), .phase_drive(phase_drive),
  .rotation_pulse_out(rotation_pulse_out)
);

/* File: hall_motor_model.sv */
// Hall sensor model of a turning or stalled motor
`timescale 1ns/100ps
module hall_motor_model #(
  parameter int STEP_CYCLES = 1000
) (
  input wire logic pclk, // System clock
  input wire logic spin, // Motor turning
  input wire logic [1:0] bad, // 1 all low, 2 all high
  output logic [2:0] hall_in // Hall levels {u,v,w}
);
  logic [2:0] seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  int idx = 0;
  int cnt = 0;
  initial hall_in = 3'h5;
  // Gray order: one Hall edge per 60 degree step
  always @(posedge pclk) begin
    if (spin && cnt == STEP_CYCLES - 1) begin
      cnt <= 0;
      idx <= (idx + 1) % 6;
    end else if (spin) begin
      cnt <= cnt + 1;
    end
    hall_in <= bad[1] ? 3'h7 : bad[0] ? 3'h0 : seq[idx];
  end
endmodule : hall_motor_model

/* File: sine_pwm_commutation_control_tb.sv */
// Self-checking bench for the commutation block
`timescale 1ns/100ps
module sine_pwm_commutation_control_tb;
  import motor_pkg::*;
  localparam int LOCK_CYC = LOCK_TICKS * REF_DIV;
  localparam int CARR_CYC = CARRIER_DIV * REF_DIV;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, w;
  logic pready, pslverr, err, rotation_pulse_out, pulse_q = 0;
  logic [2:0] hall_in;
  logic [7:0] speed = 8'hFF;
  logic [7:0] stop_tab [4] = '{8'h00, 8'h1D, 8'h1E, 8'hFF};
  logic [4:0] lead = 5'h00;
  logic dir_sel = 0, restart_sel = 1, oc = 0, ext_rst = 0, sup_ok = 1;
  logic spin = 0, count_on = 0, ce = 1;
  logic [1:0] bad = 2'h0;
  phase_drive_type phase_drive;
  int error_cnt = 0, n_compared = 0, cyc = 0, rises = 0, t0, sine0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    pulse_q <= rotation_pulse_out;
    if (count_on && rotation_pulse_out && !pulse_q) rises <= rises + 1;
  end
  hall_motor_model mot_u (.pclk(pclk), .spin(spin), .bad(bad),
    .hall_in(hall_in));
  sine_pwm_commutation_control #(.SLOW_EDGE_CYCLES(200),
    .LOCK_BASE_CYCLES(1)) dut_u (.pclk(pclk), .presetn(presetn),
    .clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hall_in(hall_in), .speed_command_level(speed),
    .lead_angle_setting(lead), .direction_select(dir_sel),
    .lock_restart_select(restart_sel), .current_sense_input(oc),
    .ext_reset_in(ext_rst), .motor_supply_ok(sup_ok),
    .phase_drive(phase_drive), .rotation_pulse_out(rotation_pulse_out));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Polls one STATUS bit; t0 returns the cycles it took
  task automatic wait_st(input int b, input logic v, input int lim);
    t0 = cyc;
    do apb(0, STATUS_ADDR, 0);
    while (rd[b] !== v && cyc - t0 < lim);
    t0 = cyc - t0;
  endtask : wait_st
  task automatic do_reset();
    presetn <= 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
  endtask : do_reset
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (95000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h37bb438b));
    do_reset();
    apb(0, CTRL_ADDR, 0);
    chk(rd, CTRL_RESET);
    w = $urandom | 32'h0000_0001;
    apb(1, CTRL_ADDR, w);
    apb(0, CTRL_ADDR, 0);
    chk(rd, w & CTRL_MASK);
    // Frozen clock enable must drop the write
    ce <= 0;
    apb(1, CTRL_ADDR, ~w);
    ce <= 1;
    apb(0, CTRL_ADDR, 0);
    chk(rd, w & CTRL_MASK);
    apb(0, 8'h0C, 0);
    chk({rd[30:0], err}, 32'h0000_0001);
    foreach (stop_tab[k]) begin
      speed <= stop_tab[k];
      repeat (4) @(posedge pclk);
      apb(0, STATUS_ADDR, 0);
      chk(rd[7], k > 1);
    end
    for (int k = 0; k < 3; k++) begin
      ext_rst <= k == 0;
      sup_ok <= k != 1;
      oc <= k == 2;
      repeat (4) @(posedge pclk);
      apb(0, STATUS_ADDR, 0);
      chk(rd[7], 0);
    end
    chk(rd[3], 1);
    oc <= 0;
    wait_st(3, 0, CARR_CYC + 200);
    chk(t0 <= CARR_CYC + 10, 1);
    chk(rd[7], 1);
    chk(phase_drive.low, 3'h2);
    for (int k = 1; k < 3; k++) begin
      bad <= 2'(k);
      repeat (4) @(posedge pclk);
      apb(0, STATUS_ADDR, 0);
      chk({rd[10:8], rd[4]}, 4'hF);
      bad <= 2'h0;
      wait_st(4, 0, CARR_CYC + 200);
      chk(t0 <= CARR_CYC + 10, 1);
    end
    // Fresh start so earlier stalls do not feed the lock timer
    do_reset();
    speed <= 8'h1E + 8'($urandom % 226);
    lead <= 5'($urandom);
    spin <= 1;
    repeat (6500) @(posedge pclk);
    count_on <= 1;
    repeat (12000) @(posedge pclk);
    count_on <= 0;
    chk(rises, 3 * 12 / 6);
    apb(0, STATUS_ADDR, 0);
    sine0 = rd[0];
    chk(rd[1], 0);
    chk(rd[2:0], 3'h5);
    dir_sel <= 1;
    repeat (9000) @(posedge pclk);
    apb(0, STATUS_ADDR, 0);
    chk(rd[0] ^ sine0[0], 1);
    spin <= 0;
    wait_st(1, 1, 4000);
    chk(rd[1:0], 2'h2);
    for (int k = 1; k >= 0; k--) begin
      wait_st(6, k, LOCK_CYC + 500);
      chk(t0 > LOCK_CYC - 40 && t0 < LOCK_CYC + 40, 1);
      chk(rd[7], k == 0);
    end
    restart_sel <= 0;
    do_reset();
    for (int k = 0; k < 2; k++) begin
      wait_st(5, 1, LOCK_CYC + 500);
      chk({rd[5], rd[7]}, 2'h2);
      sup_ok <= k != 0;
      speed <= k == 0 ? 8'hFF : 8'h00;
      repeat (20) @(posedge pclk);
      sup_ok <= 1;
      speed <= 8'hFF;
      apb(0, STATUS_ADDR, 0);
      chk(rd[5], 0);
    end
    end_sim();
  end
endmodule : sine_pwm_commutation_control_tb
